// [core/cft_core.sv]
// CAN fault confinement, error counters and bit timing with a Wishbone slave
`timescale 1ns/100ps
`include "cft_defs.svh"
module cft_core
    import cft_pkg::*;
(
    input wire logic sys_clk_i,         // Module input clock, 25 MHz
    input wire logic rst_b_i,           // Asynchronous reset, active low
    input wire logic [7:0] wb_adr_i,    // Wishbone byte address
    input wire logic [31:0] wb_dat_i,   // Wishbone write data
    input wire logic [3:0] wb_sel_i,    // Wishbone byte selects
    input wire logic wb_we_i,           // Wishbone write enable
    input wire logic wb_cyc_i,          // Wishbone cycle
    input wire logic wb_stb_i,          // Wishbone strobe
    output logic [31:0] wb_dat_o,       // Wishbone read data
    output logic wb_ack_o,              // Wishbone acknowledge
    input wire logic can_rx_i,          // Bus level, 1 is recessive
    input wire logic flag_req_i,        // Frame logic wants an error flag now
    output logic flag_dominant_o,       // Flag must be dominant (active)
    output logic bus_on_o,              // Drivers enabled
    output logic sample_o,              // Sample point pulse
    output logic tx_point_o,            // Transmission point pulse
    output logic rx_bit_o,              // Sampled bit
    output logic [2:0] fault_state_o    // Fault confinement state
);
    cft_state_t s_q, s_d;

    // Overview of operation
    // The whole block state lives in one packed struct.
    // One combinational process builds the next copy.
    // One clocked process registers that copy.
    // Nothing else holds state in this module.
    //
    // Register bus
    // Every access is answered one cycle after it is taken.
    // The answer is a single-cycle acknowledge pulse.
    // A request is taken only while acknowledge is low.
    // So a request is never taken again in its acknowledge cycle.
    // Writes take effect at the edge that takes them.
    // Read data is latched at the same edge.
    // Read data then stands until the next request.
    // Unmapped reads give zero and are still answered.
    // Unmapped writes are dropped and still answered.
    // The event word reads back as zero.
    // Byte selects gate the timing word lane by lane.
    // The event word only listens to lane zero.
    //
    // Timing word
    // Low byte holds the quantum prescale value.
    // Next nibble holds the first segment length.
    // Next nibble holds the second segment length.
    // Two bits hold the resynchronisation jump width.
    // The top bit enables the controller.
    // Software must keep the jump width small enough.
    // The hardware does not clip a jump width too large.
    // A large jump width only distorts bit timing.
    // It cannot lock up the state machines.
    //
    // Prescaler
    // The counter runs on every clock.
    // It emits one quantum tick per wrap.
    // A zero setting behaves as divide by one.
    // That avoids a dead quantum clock after a bad write.
    //
    // Bit segments
    // The sync segment is always one quantum.
    // The first segment follows and ends at the sample.
    // The second segment follows and ends at transmit.
    // The sample pulse is registered one cycle late.
    // The transmit pulse is registered as well.
    // The sampled bit stands until the next sample.
    //
    // Hard synchronisation
    // A falling edge seen on an idle bus is a frame start.
    // While waiting for the bus every falling edge counts.
    // Hard sync restarts the first segment at once.
    //
    // Soft synchronisation
    // An edge inside the first segment is late.
    // An edge inside the second segment is early.
    // A small phase error acts like a hard sync.
    // A large late error stretches the first segment.
    // A large early error cuts the second segment.
    // The stretch or cut is the jump width.
    // The stretched length only lasts for this bit.
    // It is reloaded from the timing word each bit.
    //
    // Idle detection
    // Recessive samples are counted in a small run counter.
    // Any dominant sample clears the run.
    // Outside bus-off the run saturates at eleven.
    // A saturated run marks the bus as idle.
    // In bus-off the run wraps after eleven bits.
    // Each wrap counts one recovery sequence.
    //
    // Error counters
    // Frame logic reports events through the event word.
    // Several events may be written in one word.
    // Decrements are applied before increments.
    // A counter at zero is not decremented.
    // The receive counter stops counting up once its top bit is set.
    // An exempt flag written with a transmit error blocks it.
    // Nine-bit sums keep headroom for the compares.
    // The stored counters saturate at their maximum.
    // A transmit sum past the maximum forces bus-off.
    // Counter events are ignored while waiting or bus-off.
    //
    // Fault confinement
    // Warning and passive are recomputed every cycle.
    // The compares use the updated counter values.
    // So the state follows a counter change at once.
    // Bus-off is left through the recovery count, or to waiting on disable or wake-up.
    // Leaving bus-off through recovery clears both counters.
    // Entering bus-off restarts the recessive run.
    // A partial run cannot then shorten the recovery.
    //
    // Waiting for the bus
    // Enable going high restarts the wait.
    // Enable low keeps the block waiting.
    // A wake-up event restarts the wait too.
    // The wait ends after eleven recessive samples.
    // The bus drivers stay off while waiting.
    //
    // Error flags
    // Frame logic asks for a flag with a level input.
    // The answer is combinational from the state register.
    // A flag asked for at passive entry uses the old state.
    // So that flag still goes out dominant.
    // Later flags while passive are recessive.
    //
    // Limitations
    // Frame coding and stuffing live outside this block.
    // Dominant run lengths after a flag are counted outside.
    // Only the resulting events reach the counters here.
    // The bus input is taken as already synchronous.
    // A metastable bus level must be filtered upstream.
    // The drivers flag is a permission, not a pin drive.
    // Transmit data itself is handled by the frame logic.

    // Read mux decode, used by the bus slave
    function automatic logic [31:0] rd_mux(input logic [7:0] a, input cft_state_t s);
        unique case (a)
            `CFT_ADR_TIMING: rd_mux = s.timing;
            `CFT_ADR_ERRCNT: rd_mux = {16'h0000, s.cnt};
            `CFT_ADR_STATUS: rd_mux = {29'h0000_0000, s.fst};
            default: rd_mux = 32'h0000_0000;
        endcase
    endfunction

    // Add into a nine-bit headroom value; taken at nine bits, the sum wraps and the 9'h1ff clamp never fires
    function automatic logic [8:0] sat_add(input logic [8:0] v, input logic [8:0] k);
        sat_add = (v + k > 9'h1ff) ? 9'h1ff : 9'(v + k);
    endfunction

    logic wr;
    logic [7:0] ev;
    logic [7:0] pre_div;
    logic [4:0] ts1, ts2, jump_w;
    logic tq_tick, fall_edge, bus_idle;
    logic [8:0] rxc, txc;
    logic [4:0] e_mag;

    always_comb begin
        // Defaults carry the state forward
        s_d = s_q;
        wr = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
        ev = (wr && wb_adr_i == `CFT_ADR_EVENT && wb_sel_i[0]) ? wb_dat_i[7:0] : 8'h00;
        pre_div = s_q.timing[`CFT_PRE_MSB:`CFT_PRE_LSB];
        ts1 = {1'b0, s_q.timing[`CFT_TS1_MSB:`CFT_TS1_LSB]};
        ts2 = {1'b0, s_q.timing[`CFT_TS2_MSB:`CFT_TS2_LSB]};
        jump_w = {3'b000, s_q.timing[`CFT_JMP_MSB:`CFT_JMP_LSB]};
        s_d.sample = 1'b0;
        s_d.txpt = 1'b0;
        e_mag = 5'h00;

        // Bus slave: one-cycle answer, ack dropped after one cycle
        s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
        if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
            s_d.rdat = rd_mux(wb_adr_i, s_q);
        end
        if (wr && wb_adr_i == `CFT_ADR_TIMING) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    s_d.timing[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                end
            end
        end

        // Prescaler: a zero setting behaves as divide by one
        tq_tick = 1'b0;
        if (s_q.pre_cnt + 8'h01 >= pre_div) begin
            s_d.pre_cnt = 8'h00;
            tq_tick = 1'b1;
        end else begin
            s_d.pre_cnt = s_q.pre_cnt + 8'h01;
        end

        // Bit timing per quantum
        bus_idle = (s_q.rec_run >= `CFT_IDLE_BITS);
        fall_edge = s_q.rx_prev && !can_rx_i;
        if (tq_tick) begin
            s_d.rx_prev = can_rx_i;
            if (fall_edge && (bus_idle || s_q.fst == CFT_SYNC)) begin
                // Start of frame restarts the bit timing
                s_d.seg = CFT_SEG_ONE;
                s_d.tq_cnt = 5'h00;
                s_d.seg1_len = ts1;
            end else if (fall_edge && s_q.seg == CFT_SEG_ONE) begin
                // Late edge: positive phase error
                e_mag = s_q.tq_cnt + 5'h01;
                if (e_mag <= jump_w) begin
                    s_d.seg = CFT_SEG_ONE;
                    s_d.tq_cnt = 5'h00;
                    s_d.seg1_len = ts1;
                end else begin
                    s_d.seg1_len = s_q.seg1_len + jump_w;
                    s_d.tq_cnt = s_q.tq_cnt + 5'h01;
                end
            end else if (fall_edge && s_q.seg == CFT_SEG_TWO) begin
                // Early edge: negative phase error
                e_mag = ts2 - s_q.tq_cnt;
                if (e_mag <= jump_w) begin
                    s_d.seg = CFT_SEG_ONE;
                    s_d.tq_cnt = 5'h00;
                    s_d.seg1_len = ts1;
                end else begin
                    s_d.tq_cnt = s_q.tq_cnt + jump_w + 5'h01;
                    if (s_q.tq_cnt + jump_w + 5'h01 >= ts2) begin
                        s_d.seg = CFT_SEG_SYNC;
                        s_d.tq_cnt = 5'h00;
                        s_d.txpt = 1'b1;
                    end
                end
            end else begin
                unique case (s_q.seg)
                    CFT_SEG_SYNC: begin
                        s_d.seg = CFT_SEG_ONE;
                        s_d.tq_cnt = 5'h00;
                        s_d.seg1_len = ts1;
                    end
                    CFT_SEG_ONE: begin
                        if (s_q.tq_cnt + 5'h01 >= s_q.seg1_len) begin
                            // Sample between the two segments
                            s_d.seg = CFT_SEG_TWO;
                            s_d.tq_cnt = 5'h00;
                            s_d.sample = 1'b1;
                            s_d.rx_bit = can_rx_i;
                        end else begin
                            s_d.tq_cnt = s_q.tq_cnt + 5'h01;
                        end
                    end
                    CFT_SEG_TWO: begin
                        if (s_q.tq_cnt + 5'h01 >= ts2) begin
                            s_d.seg = CFT_SEG_SYNC;
                            s_d.tq_cnt = 5'h00;
                            s_d.txpt = 1'b1;
                        end else begin
                            s_d.tq_cnt = s_q.tq_cnt + 5'h01;
                        end
                    end
                    default: s_d.seg = CFT_SEG_SYNC;
                endcase
            end
        end

        // Recessive run counter at each sample point
        if (s_q.sample) begin
            if (!s_q.rx_bit) begin
                s_d.rec_run = 4'h0;
            end else if (s_q.fst == CFT_BUSOFF && s_q.rec_run >= `CFT_IDLE_BITS - 4'h1) begin
                // Bus-off counts whole sequences of eleven
                s_d.rec_run = 4'h0;
            end else if (s_q.rec_run < `CFT_IDLE_BITS) begin
                // Elsewhere the run saturates so idle stays visible
                s_d.rec_run = s_q.rec_run + 4'h1;
            end
        end

        // Error counters with headroom for the comparisons
        rxc = {1'b0, s_q.cnt.rx_error_count};
        txc = {1'b0, s_q.cnt.tx_error_count};
        if (s_q.fst != CFT_SYNC && s_q.fst != CFT_BUSOFF) begin
            if (ev[`CFT_EV_RXVALID] && rxc != 9'h000) rxc = rxc - `CFT_STEP_ONE;
            if (ev[`CFT_EV_TXVALID] && txc != 9'h000) txc = txc - `CFT_STEP_ONE;
            if (!s_q.cnt.rx_error_count[7]) begin
                if (ev[`CFT_EV_RXERR1]) rxc = sat_add(rxc, `CFT_STEP_ONE);
                if (ev[`CFT_EV_RXERR8]) rxc = sat_add(rxc, `CFT_STEP_BIG);
                if (ev[`CFT_EV_DOMSEQ]) rxc = sat_add(rxc, `CFT_STEP_BIG);
            end
            if (ev[`CFT_EV_TXERR8] && !ev[`CFT_EV_TXEXEMPT]) begin
                txc = sat_add(txc, `CFT_STEP_BIG);
            end
            if (ev[`CFT_EV_DOMSEQ]) txc = sat_add(txc, `CFT_STEP_BIG);
            // Counter past 255 is kept at 255 while bus-off is entered
            s_d.cnt.rx_error_count = (rxc > 9'h0ff) ? 8'hff : rxc[7:0];
            s_d.cnt.tx_error_count = (txc > 9'h0ff) ? 8'hff : txc[7:0];
        end

        // Fault confinement state
        s_d.en_d1 = s_q.timing[`CFT_EN_BIT];
        if (!s_q.timing[`CFT_EN_BIT] || (s_q.timing[`CFT_EN_BIT] && !s_q.en_d1)
            || ev[`CFT_EV_WAKE]) begin
            s_d.fst = CFT_SYNC;
            s_d.rec_run = 4'h0;
        end else begin
            unique case (s_q.fst)
                CFT_SYNC: begin
                    if (s_q.sample && s_q.rx_bit && s_q.rec_run == `CFT_IDLE_BITS - 4'h1) begin
                        s_d.fst = CFT_ACTIVE;
                    end
                end
                CFT_BUSOFF: begin
                    if (s_q.sample && s_q.rx_bit && s_q.rec_run == `CFT_IDLE_BITS - 4'h1) begin
                        if (s_q.seq_cnt + 8'h01 >= `CFT_BOFF_SEQS) begin
                            s_d.fst = CFT_ACTIVE;
                            s_d.seq_cnt = 8'h00;
                            s_d.cnt = '0;
                        end else begin
                            s_d.seq_cnt = s_q.seq_cnt + 8'h01;
                        end
                    end
                end
                default: begin
                    if (txc >= `CFT_BOFF_LIMIT) begin
                        s_d.fst = CFT_BUSOFF;
                        s_d.seq_cnt = 8'h00;
                        s_d.rec_run = 4'h0;
                    end else if (rxc >= `CFT_PASS_LIMIT || txc >= `CFT_PASS_LIMIT) begin
                        s_d.fst = CFT_PASSIVE;
                    end else if (rxc >= `CFT_WARN_LIMIT || txc >= `CFT_WARN_LIMIT) begin
                        s_d.fst = CFT_WARNING;
                    end else begin
                        s_d.fst = CFT_ACTIVE;
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '{fst: CFT_SYNC, timing: `CFT_TIMING_RST, seg: CFT_SEG_SYNC,
                     rx_prev: 1'b1, rx_bit: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs; a flag asked for during passive entry is judged on the old state
    assign wb_dat_o = s_q.rdat;
    assign wb_ack_o = s_q.ack;
    assign flag_dominant_o = flag_req_i && (s_q.fst == CFT_ACTIVE || s_q.fst == CFT_WARNING);
    assign bus_on_o = (s_q.fst != CFT_BUSOFF) && (s_q.fst != CFT_SYNC);
    assign sample_o = s_q.sample;
    assign tx_point_o = s_q.txpt;
    assign rx_bit_o = s_q.rx_bit;
    assign fault_state_o = s_q.fst;
endmodule // cft_core

// [core/cft_defs.svh]
// Constant definitions for the CAN fault-confinement and bit-timing block
`ifndef CFT_DEFS_SVH
`define CFT_DEFS_SVH
// Wishbone word offsets (byte addresses)
`define CFT_ADR_TIMING    8'h00
`define CFT_ADR_ERRCNT    8'h04
`define CFT_ADR_STATUS    8'h08
`define CFT_ADR_EVENT     8'h0c
// Timing register field positions
`define CFT_PRE_LSB       0
`define CFT_PRE_MSB       7
`define CFT_TS1_LSB       8
`define CFT_TS1_MSB       11
`define CFT_TS2_LSB       12
`define CFT_TS2_MSB       15
`define CFT_JMP_LSB       16
`define CFT_JMP_MSB       17
`define CFT_EN_BIT        31
// Timing register reset value: prescale 1, seg1 5, seg2 4, jump 1, disabled
`define CFT_TIMING_RST    32'h0001_4501
// Event register bits (write one to pulse)
`define CFT_EV_RXVALID    0
`define CFT_EV_TXVALID    1
`define CFT_EV_RXERR1     2
`define CFT_EV_RXERR8     3
`define CFT_EV_TXERR8     4
`define CFT_EV_DOMSEQ     5
`define CFT_EV_TXEXEMPT   6
`define CFT_EV_WAKE       7
// Fault-confinement thresholds
`define CFT_IDLE_BITS     4'hb
`define CFT_WARN_LIMIT    9'h060
`define CFT_PASS_LIMIT    9'h080
`define CFT_BOFF_LIMIT    9'h100
`define CFT_BOFF_SEQS     8'h80
`define CFT_STEP_BIG      9'h008
`define CFT_STEP_ONE      9'h001
`endif

// [core/cft_pkg.sv]
// Types for the CAN fault-confinement and bit-timing block
package cft_pkg;
    typedef enum logic [2:0] {
        CFT_SYNC    = 3'b000,
        CFT_ACTIVE  = 3'b001,
        CFT_WARNING = 3'b010,
        CFT_PASSIVE = 3'b011,
        CFT_BUSOFF  = 3'b100
    } cft_fstate_t;
    typedef enum logic [1:0] {
        CFT_SEG_SYNC = 2'b00,
        CFT_SEG_ONE  = 2'b01,
        CFT_SEG_TWO  = 2'b10
    } cft_seg_t;
    typedef struct packed {
        logic [7:0] rx_error_count;
        logic [7:0] tx_error_count;
    } cft_cnt_t;
    typedef struct packed {
        cft_fstate_t fst;      // Fault confinement state
        cft_cnt_t    cnt;      // Both error counters
        logic [31:0] timing;   // Timing and enable register
        logic        en_d1;    // Enable seen last cycle
        logic [7:0]  pre_cnt;  // Prescaler count
        cft_seg_t    seg;      // Current bit segment
        logic [4:0]  tq_cnt;   // Quantum within segment
        logic [4:0]  seg1_len; // Possibly lengthened first segment
        logic        rx_prev;  // Bus level at previous quantum
        logic        rx_bit;   // Last sampled bit
        logic        sample;   // Sample point pulse
        logic        txpt;     // Transmission point pulse
        logic [3:0]  rec_run;  // Recessive bit run length
        logic [7:0]  seq_cnt;  // Eleven-bit sequences seen in bus-off
        logic        ack;      // Wishbone acknowledge
        logic [31:0] rdat;     // Wishbone read data
    } cft_state_t;
endpackage

// [tb/cft_core_props.sv]
// Concurrent checks on the fault-confinement and bit-timing core
`timescale 1ns/100ps
module cft_core_props (
    input wire logic sys_clk_i, // Clock
    input wire logic rst_b_i, // Reset, active low
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_ack_o, // Bus acknowledge
    input wire logic flag_req_i, // Flag wanted
    input wire logic flag_dominant_o, // Flag dominant
    input wire logic bus_on_o, // Drivers on
    input wire logic sample_o, // Sample pulse
    input wire logic tx_point_o, // Transmit pulse
    input wire logic rx_bit_o, // Sampled bit
    input wire logic [2:0] fault_state_o // Confinement state
);
    logic [3:0] run_q; // Recessive samples seen in sync
    logic [10:0] boff_q; // Recessive samples seen in bus-off
    // Counters saturate, so a long idle spell cannot wrap them
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_q <= 4'h0;
            boff_q <= 11'h000;
        end else begin
            if (fault_state_o != 3'h0 || (sample_o && !rx_bit_o))
                run_q <= 4'h0;
            else if (sample_o && run_q != 4'hf)
                run_q <= run_q + 4'h1;
            if (fault_state_o != 3'h4)
                boff_q <= 11'h000;
            else if (sample_o && rx_bit_o && boff_q != 11'h7ff)
                boff_q <= boff_q + 11'h001;
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no acknowledge one cycle after a request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");
    a_sync_quiet: assert property (fault_state_o == 3'h0 |-> !bus_on_o)
        else $error("drivers on while waiting for the bus");
    a_boff_quiet: assert property (fault_state_o == 3'h4 |-> !bus_on_o)
        else $error("drivers on while bus-off");
    a_flag_active: assert property (flag_req_i && fault_state_o inside {3'h1, 3'h2}
        |-> flag_dominant_o)
        else $error("recessive flag while active");
    a_flag_passive: assert property ($rose(flag_req_i) && fault_state_o == 3'h3
        && $stable(fault_state_o) |-> !flag_dominant_o)
        else $error("dominant flag while passive");
    a_sample_apart: assert property (sample_o |-> !tx_point_o)
        else $error("sample and transmit point coincide");
    a_sync_wait: assert property (fault_state_o == 3'h0 ##1 fault_state_o == 3'h1
        |-> run_q >= 4'ha)
        else $error("left sync before eleven recessive bits");
    a_boff_wait: assert property (fault_state_o == 3'h4 ##1 fault_state_o == 3'h1
        |-> boff_q >= 11'h578)
        else $error("left bus-off too early");
    c_busoff: cover property (fault_state_o == 3'h4);
    c_warning: cover property (fault_state_o == 3'h2);
    c_passive_flag: cover property (flag_req_i && fault_state_o == 3'h3);
endmodule // cft_core_props

bind cft_core cft_core_props u_cft_core_props (.sys_clk_i, .rst_b_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .flag_req_i, .flag_dominant_o, .bus_on_o, .sample_o, .tx_point_o,
    .rx_bit_o, .fault_state_o);

// [tb/cft_can_node.sv]
// Model of the other nodes sharing the bus
`timescale 1ns/100ps
module cft_can_node #(
    parameter int BIT_CYC = 4 // Clocks per bit
) (
    input wire logic sys_clk_i, // Clock
    input wire logic dom_i, // Ask for dominant bits
    output logic can_rx_o // Wired bus level, 1 is recessive
);
    int phase_q = 0; // Clock within the current bit
    logic lvl_q = 1'b1; // Released bus idles recessive
    // Level moves only at bit boundaries, so edges hit the idle bus as a frame start
    always @(posedge sys_clk_i) begin
        phase_q <= (phase_q == BIT_CYC - 1) ? 0 : phase_q + 1;
        if (phase_q == 0)
            lvl_q <= !dom_i;
    end
    assign can_rx_o = lvl_q;
endmodule // cft_can_node

// [tb/cft_core_tb.sv]
// Self-checking bench for the fault-confinement and bit-timing core
`timescale 1ns/100ps
module cft_core_tb
    import cft_pkg::*;
;
    typedef struct packed {
        logic [7:0] ev; // Event bits written
        logic [15:0] cnt; // Expected counter word
        logic [2:0] st; // Expected state
    } cft_row_t;
    localparam logic [31:0] TIM = 32'h8001_1201; // On, jump 1, seg2 1, seg1 2, prescale 1
    logic sys_clk_i, rst_b_i; // Clock and reset
    logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o; // Bus handshake
    logic [7:0] wb_adr_i; // Address
    logic [31:0] wb_dat_i, wb_dat_o, rd; // Data and last read
    logic can_rx_i, flag_req_i, flag_dominant_o, bus_on_o; // Bus side
    logic sample_o, tx_point_o, rx_bit_o, dom; // Timing outputs, partner request
    logic [2:0] fault_state_o; // State
    int err_count = 0; // Mismatches
    int samples_checked = 0; // Comparisons
    int sgap = 0; // Clocks between the last two samples
    int scnt = 0; // Clocks since the last sample
    int n; // Cycles spent in the last wait
    cft_row_t rows [7] = '{'{8'h08, 16'h0800, 3'h1}, '{8'h04, 16'h0900, 3'h1},
        '{8'h01, 16'h0800, 3'h1}, '{8'h10, 16'h0808, 3'h1}, '{8'h02, 16'h0807, 3'h1},
        '{8'h20, 16'h100f, 3'h1}, '{8'h50, 16'h100f, 3'h1}};
    cft_core u_cft_core (.sys_clk_i, .rst_b_i, .wb_adr_i, .wb_dat_i, .wb_sel_i(4'hf),
        .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .can_rx_i, .flag_req_i,
        .flag_dominant_o, .bus_on_o, .sample_o, .tx_point_o, .rx_bit_o, .fault_state_o);
    cft_can_node u_cft_can_node (.sys_clk_i, .dom_i(dom), .can_rx_o(can_rx_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    // Sample spacing shows the bit length in clocks
    always @(posedge sys_clk_i) begin
        if (sample_o === 1'b1) begin
            sgap <= scnt;
            scnt <= 1;
        end else
            scnt <= scnt + 1;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic tmo;
        err_count++;
        $display("unexpected at %0t: wait ran out", $time);
        end_of_test();
    endtask
    // One classic cycle; the request stands until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        @(posedge sys_clk_i);
        while (wb_ack_o !== 1'b1 && k < 20) begin
            k++;
            @(posedge sys_clk_i);
        end
        if (k == 20)
            tmo();
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge sys_clk_i);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic ev(input logic [7:0] b);
        wb(1'b1, 8'h0c, {24'h0, b});
    endtask
    task automatic wait_st(input logic [2:0] s, input int lim);
        n = 0;
        while (fault_state_o !== s && n < lim) begin
            n++;
            @(posedge sys_clk_i);
        end
        if (n == lim)
            tmo();
    endtask
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, flag_req_i, dom} <= '0;
        rst_b_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(posedge sys_clk_i);
        rc(8'h00, 32'h0001_4501);
        rc(8'h14, 32'h0);
        chk(bus_on_o, 1'b0);
        wb(1'b1, 8'h00, TIM);
        wait_st(CFT_ACTIVE, 200);
        chk(n >= 36, 1'b1);
        repeat (12) @(posedge sys_clk_i);
        chk(sgap, 32'h4);
        wb(1'b1, 8'h00, TIM + 32'h1);
        repeat (24) @(posedge sys_clk_i);
        chk(sgap, 32'h8);
        wb(1'b1, 8'h00, TIM);
        $display("timing tests done");
        // Ordinary event table
        foreach (rows[i]) begin
            ev(rows[i].ev);
            rc(8'h04, {16'h0, rows[i].cnt});
            chk(fault_state_o, rows[i].st);
        end
        $display("table tests done");
        // Thresholds: warning, back to active, passive, receive count held once its top bit is set
        repeat (10) ev(8'h08);
        rc(8'h04, 32'h600f);
        chk(fault_state_o, CFT_WARNING);
        rc(8'h08, 32'h2);
        flag_req_i <= 1'b1;
        @(posedge sys_clk_i);
        chk(flag_dominant_o, 1'b1);
        flag_req_i <= 1'b0;
        ev(8'h01);
        rc(8'h04, 32'h5f0f);
        chk(fault_state_o, CFT_ACTIVE);
        repeat (4) ev(8'h08);
        ev(8'h04);
        rc(8'h04, 32'h800f);
        chk(fault_state_o, CFT_PASSIVE);
        flag_req_i <= 1'b1;
        @(posedge sys_clk_i);
        chk(flag_dominant_o, 1'b0);
        flag_req_i <= 1'b0;
        ev(8'h08);
        rc(8'h04, 32'h800f);
        ev(8'h01);
        rc(8'h04, 32'h7f0f);
        chk(fault_state_o, CFT_WARNING);
        // Bus-off and its long recovery
        repeat (30) ev(8'h10);
        rc(8'h04, 32'h7fff);
        ev(8'h10);
        chk(fault_state_o, CFT_BUSOFF);
        chk(bus_on_o, 1'b0);
        wait_st(CFT_ACTIVE, 7000);
        chk(n >= 5500, 1'b1);
        rc(8'h04, 32'h0);
        $display("confinement tests done");
        // Wake-up waits out a dominant spell, then eleven recessive bits
        ev(8'h80);
        chk(fault_state_o, CFT_SYNC);
        dom <= 1'b1;
        repeat (80) @(posedge sys_clk_i);
        chk(fault_state_o, CFT_SYNC);
        dom <= 1'b0;
        wait_st(CFT_ACTIVE, 200);
        chk(n >= 36, 1'b1);
        wb(1'b1, 8'h00, 32'h0001_1201);
        wb(1'b1, 8'h00, TIM);
        chk(fault_state_o, CFT_SYNC);
        wait_st(CFT_ACTIVE, 200);
        ev(8'h03);
        rc(8'h04, 32'h0);
        $display("resync tests done");
        end_of_test();
    end
endmodule // cft_core_tb
